// ===== common/frx_pkg.sv
// Constants and types shared by the file register execute stage.
// Assumes a 12-bit instruction word and an 8-bit data path.
package frx_pkg;

  localparam int INSTR_W = 12;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 5;
  localparam int PC_W = 11;
  localparam int JUMP_W = 9;
  localparam int STATUS_W = 8;

  // Field positions inside the instruction word.
  localparam int FADDR_LSB = 0;
  localparam int DEST_BIT = 5;
  localparam int LIT_LSB = 0;
  localparam int JUMP_LSB = 0;
  // Page select bits inside the status register.
  localparam int PAGE_HI = 6;
  localparam int PAGE_LO = 5;

  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
  localparam logic [PC_W-1:0] PC_RESET = 11'h000;

  // Opcode match patterns: the instruction is masked and then compared.
  localparam logic [INSTR_W-1:0] MASK_FILE_OP = 12'hFE0;
  localparam logic [INSTR_W-1:0] MASK_FILE_D = 12'hFC0;
  localparam logic [INSTR_W-1:0] MASK_JUMP = 12'hE00;
  localparam logic [INSTR_W-1:0] MASK_LIT = 12'hF00;
  localparam logic [INSTR_W-1:0] CODE_CLEAR = 12'h060;
  localparam logic [INSTR_W-1:0] CODE_INVERT = 12'h240;
  localparam logic [INSTR_W-1:0] CODE_DEC = 12'h0C0;
  localparam logic [INSTR_W-1:0] CODE_DEC_SKIP = 12'h2C0;
  localparam logic [INSTR_W-1:0] CODE_INC = 12'h280;
  localparam logic [INSTR_W-1:0] CODE_INC_SKIP = 12'h3C0;
  localparam logic [INSTR_W-1:0] CODE_JUMP = 12'hA00;
  localparam logic [INSTR_W-1:0] CODE_OR_LIT = 12'hD00;

  typedef enum logic [3:0] {
    FRX_OP_NONE = 4'h0,
    FRX_OP_CLEAR = 4'h1,
    FRX_OP_INVERT = 4'h2,
    FRX_OP_DEC = 4'h3,
    FRX_OP_DEC_SKIP = 4'h4,
    FRX_OP_INC = 4'h5,
    FRX_OP_INC_SKIP = 4'h6,
    FRX_OP_JUMP = 4'h7,
    FRX_OP_OR_LIT = 4'h8
  } frx_op_t;

  typedef enum logic [0:0] {
    FRX_ST_EXEC = 1'b0,
    FRX_ST_FLUSH = 1'b1
  } frx_state_t;

endpackage : frx_pkg

// ===== src/frx_alu.sv
// Result unit of the file register execute stage.
// Purely combinational; the caller registers what it needs.
`timescale 1ns/1ns
module frx_alu (
  input wire frx_pkg::frx_op_t op,
  input wire logic [frx_pkg::DATA_W-1:0] file_value,
  input wire logic [frx_pkg::DATA_W-1:0] accum_value,
  input wire logic [frx_pkg::DATA_W-1:0] literal,
  output logic [frx_pkg::DATA_W-1:0] result,
  output logic result_is_null
);

  always_comb begin
    unique case (op)
      frx_pkg::FRX_OP_CLEAR: result = frx_pkg::DATA_ZERO;
      frx_pkg::FRX_OP_INVERT: result = ~file_value;
      frx_pkg::FRX_OP_DEC, frx_pkg::FRX_OP_DEC_SKIP: result = file_value - frx_pkg::DATA_ONE;
      frx_pkg::FRX_OP_INC, frx_pkg::FRX_OP_INC_SKIP: result = file_value + frx_pkg::DATA_ONE;
      frx_pkg::FRX_OP_OR_LIT: result = accum_value | literal;
      default: result = frx_pkg::DATA_ZERO;
    endcase
  end

  assign result_is_null = (result == frx_pkg::DATA_ZERO);

endmodule : frx_alu

// ===== src/frx_exec.sv
// Execute stage for clear, invert, decrement, increment (with and without skip),
// absolute jump and OR of a literal into the accumulator.
// Assumes the fetch stage presents one instruction per clock and the file register
// array answers a read combinationally on the same clock.
//
// Functional notes
// - Clearing writes zero into the addressed file register and sets the null flag.
// - Invert complements the file value and stores it by the destination bit, updating the null flag.
// - Decrement subtracts one, stores by the destination bit and updates the null flag.
// - Decrement with skip stores its result by the destination bit and leaves the null flag alone.
// - A zero result of decrement with skip discards the fetched next instruction, taking two cycles.
// - The jump loads its nine bit operand into program counter bits 8 to 0.
// - The jump copies status bits 6 and 5 into program counter bits 10 and 9.
// - The jump always takes two cycles, the second flushing the fetched sequential instruction.
// - Both increments add one and store by the destination bit, and only the plain one updates the null flag.
// - A zero result of increment with skip discards the fetched next instruction, taking two cycles.
// - OR of a literal combines the accumulator with an 8-bit literal and updates the null flag.
`timescale 1ns/1ns
module frx_exec (
  input wire logic clk,
  input wire logic reset,
  input wire logic instr_valid,
  input wire logic [frx_pkg::INSTR_W-1:0] instr,
  input wire logic [frx_pkg::STATUS_W-1:0] status_in,
  input wire logic [frx_pkg::DATA_W-1:0] file_rdata,
  output logic [frx_pkg::FADDR_W-1:0] file_addr,
  output logic file_we,
  output logic [frx_pkg::FADDR_W-1:0] file_waddr,
  output logic [frx_pkg::DATA_W-1:0] file_wdata,
  output logic [frx_pkg::DATA_W-1:0] accum_reg,
  output logic result_null_flag,
  output logic pc_load,
  output logic [frx_pkg::PC_W-1:0] pc_target,
  output logic discard_fetched
);

  ////////////////////////////////////////////////////////////////////////////////
  // Decode.

  function automatic frx_pkg::frx_op_t decode_op(input logic [frx_pkg::INSTR_W-1:0] word);
    frx_pkg::frx_op_t op;
    op = frx_pkg::FRX_OP_NONE;
    if ((word & frx_pkg::MASK_FILE_OP) == frx_pkg::CODE_CLEAR) begin
      op = frx_pkg::FRX_OP_CLEAR;
    end else if ((word & frx_pkg::MASK_FILE_D) == frx_pkg::CODE_INVERT) begin
      op = frx_pkg::FRX_OP_INVERT;
    end else if ((word & frx_pkg::MASK_FILE_D) == frx_pkg::CODE_DEC) begin
      op = frx_pkg::FRX_OP_DEC;
    end else if ((word & frx_pkg::MASK_FILE_D) == frx_pkg::CODE_DEC_SKIP) begin
      op = frx_pkg::FRX_OP_DEC_SKIP;
    end else if ((word & frx_pkg::MASK_FILE_D) == frx_pkg::CODE_INC) begin
      op = frx_pkg::FRX_OP_INC;
    end else if ((word & frx_pkg::MASK_FILE_D) == frx_pkg::CODE_INC_SKIP) begin
      op = frx_pkg::FRX_OP_INC_SKIP;
    end else if ((word & frx_pkg::MASK_JUMP) == frx_pkg::CODE_JUMP) begin
      op = frx_pkg::FRX_OP_JUMP;
    end else if ((word & frx_pkg::MASK_LIT) == frx_pkg::CODE_OR_LIT) begin
      op = frx_pkg::FRX_OP_OR_LIT;
    end
    return op;
  endfunction : decode_op

  frx_pkg::frx_state_t state;
  frx_pkg::frx_state_t next_state;
  frx_pkg::frx_op_t op;
  logic execute;
  logic dest_file;
  logic [frx_pkg::DATA_W-1:0] literal;
  logic [frx_pkg::DATA_W-1:0] result;
  logic result_is_null;
  logic is_skip_op;
  logic writes_file;
  logic writes_accum;
  logic updates_null;
  logic take_skip;
  logic take_jump;
  logic [frx_pkg::PC_W-1:0] jump_address;

  // An instruction arriving in the flush cycle is the discarded one and acts as a no-operation.
  assign execute = instr_valid && (state == frx_pkg::FRX_ST_EXEC);
  assign op = execute ? decode_op(instr) : frx_pkg::FRX_OP_NONE;
  assign dest_file = instr[frx_pkg::DEST_BIT];
  assign literal = instr[frx_pkg::LIT_LSB +: frx_pkg::DATA_W];
  assign file_addr = instr[frx_pkg::FADDR_LSB +: frx_pkg::FADDR_W];

  assign is_skip_op = (op == frx_pkg::FRX_OP_DEC_SKIP) || (op == frx_pkg::FRX_OP_INC_SKIP);
  assign writes_file = (op == frx_pkg::FRX_OP_CLEAR) ||
    (dest_file && (op inside {frx_pkg::FRX_OP_INVERT, frx_pkg::FRX_OP_DEC, frx_pkg::FRX_OP_DEC_SKIP,
    frx_pkg::FRX_OP_INC, frx_pkg::FRX_OP_INC_SKIP}));
  assign writes_accum = (op == frx_pkg::FRX_OP_OR_LIT) ||
    (!dest_file && (op inside {frx_pkg::FRX_OP_INVERT, frx_pkg::FRX_OP_DEC, frx_pkg::FRX_OP_DEC_SKIP,
    frx_pkg::FRX_OP_INC, frx_pkg::FRX_OP_INC_SKIP}));
  assign updates_null = op inside {frx_pkg::FRX_OP_CLEAR, frx_pkg::FRX_OP_INVERT, frx_pkg::FRX_OP_DEC,
    frx_pkg::FRX_OP_INC, frx_pkg::FRX_OP_OR_LIT};
  assign take_skip = is_skip_op && result_is_null;
  assign take_jump = (op == frx_pkg::FRX_OP_JUMP);
  assign jump_address = {status_in[frx_pkg::PAGE_HI:frx_pkg::PAGE_LO],
    instr[frx_pkg::JUMP_LSB +: frx_pkg::JUMP_W]};
  assign next_state = (take_skip || take_jump) ? frx_pkg::FRX_ST_FLUSH : frx_pkg::FRX_ST_EXEC;
  assign discard_fetched = (state == frx_pkg::FRX_ST_FLUSH);

  frx_alu u_alu (
    .op(op),
    .file_value(file_rdata),
    .accum_value(accum_reg),
    .literal(literal),
    .result(result),
    .result_is_null(result_is_null)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= frx_pkg::FRX_ST_EXEC;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      file_we <= 1'b0;
      file_waddr <= '0;
      file_wdata <= frx_pkg::DATA_ZERO;
    end else begin
      file_we <= writes_file;
      file_waddr <= file_addr;
      file_wdata <= result;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      accum_reg <= frx_pkg::DATA_ZERO;
      result_null_flag <= 1'b0;
    end else begin
      if (writes_accum) begin
        accum_reg <= result;
      end
      if (updates_null) begin
        result_null_flag <= result_is_null;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pc_load <= 1'b0;
      pc_target <= frx_pkg::PC_RESET;
    end else begin
      pc_load <= take_jump;
      if (take_jump) begin
        pc_target <= jump_address;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_clear_writes_zero: assert property (
    op == frx_pkg::FRX_OP_CLEAR |=> file_we && file_wdata == frx_pkg::DATA_ZERO && result_null_flag
      && file_waddr == $past(file_addr))
    else $error("clear did not write zero or set the null flag");
  a_invert_to_accum: assert property (
    op == frx_pkg::FRX_OP_INVERT && !dest_file |=> !file_we && accum_reg == ~$past(file_rdata))
    else $error("invert to accumulator gave a wrong value");
  a_decrement_to_file: assert property (
    op == frx_pkg::FRX_OP_DEC && dest_file |=> file_we && file_wdata == $past(file_rdata) - frx_pkg::DATA_ONE)
    else $error("decrement to file gave a wrong value");
  a_skip_keeps_flag: assert property (
    is_skip_op |=> $stable(result_null_flag))
    else $error("skip instruction changed the null flag");
  a_dec_skip_flush: assert property (
    op == frx_pkg::FRX_OP_DEC_SKIP && file_rdata == frx_pkg::DATA_ONE |=> discard_fetched ##1 !discard_fetched)
    else $error("decrement reaching zero did not flush exactly one instruction");
  a_jump_target: assert property (
    take_jump |=> pc_load && pc_target == {$past(status_in[frx_pkg::PAGE_HI:frx_pkg::PAGE_LO]),
      $past(instr[frx_pkg::JUMP_LSB +: frx_pkg::JUMP_W])})
    else $error("jump loaded a wrong target");
  a_jump_two_cycles: assert property (
    take_jump |=> discard_fetched && !execute ##1 !pc_load)
    else $error("jump did not flush the fetched instruction");
  a_inc_skip_flush: assert property (
    op == frx_pkg::FRX_OP_INC_SKIP |=> discard_fetched == ($past(file_rdata) == 8'hFF))
    else $error("increment with skip flushed wrongly");
  a_inc_null_flag: assert property (
    op == frx_pkg::FRX_OP_INC |=> result_null_flag == ($past(file_rdata) == 8'hFF))
    else $error("increment left a wrong null flag");
  a_or_literal: assert property (
    op == frx_pkg::FRX_OP_OR_LIT |=> accum_reg == ($past(accum_reg) | $past(literal))
      && result_null_flag == (accum_reg == frx_pkg::DATA_ZERO))
    else $error("literal OR gave a wrong accumulator or flag");
  a_single_cycle: assert property (
    op inside {frx_pkg::FRX_OP_CLEAR, frx_pkg::FRX_OP_INVERT, frx_pkg::FRX_OP_DEC, frx_pkg::FRX_OP_INC,
      frx_pkg::FRX_OP_OR_LIT} |=> !discard_fetched)
    else $error("plain instruction took more than one cycle");
  a_invert_to_file: assert property (
    op == frx_pkg::FRX_OP_INVERT && dest_file |=> file_we && file_wdata == ~$past(file_rdata))
    else $error("invert to file gave a wrong value");
  a_decrement_to_accum: assert property (
    op == frx_pkg::FRX_OP_DEC && !dest_file |=> !file_we && accum_reg == $past(file_rdata) - frx_pkg::DATA_ONE)
    else $error("decrement to accumulator gave a wrong value");
  a_dec_skip_store: assert property (
    op == frx_pkg::FRX_OP_DEC_SKIP && dest_file |=> file_we && file_wdata == $past(file_rdata) - frx_pkg::DATA_ONE)
    else $error("decrement with skip stored a wrong value");
  a_dec_skip_hold: assert property (
    op == frx_pkg::FRX_OP_DEC_SKIP && file_rdata != frx_pkg::DATA_ONE |=> !discard_fetched)
    else $error("decrement with a nonzero result flushed");
  a_inc_skip_store: assert property (
    op == frx_pkg::FRX_OP_INC_SKIP && !dest_file |=> !file_we && accum_reg == $past(file_rdata) + frx_pkg::DATA_ONE)
    else $error("increment with skip stored a wrong value");
  a_flush_no_effect: assert property (
    discard_fetched |=> !file_we && !pc_load && $stable(accum_reg) && $stable(result_null_flag))
    else $error("discarded instruction changed the machine state");
  a_dec_null_flag: assert property (
    op == frx_pkg::FRX_OP_DEC |=> result_null_flag == ($past(file_rdata) == frx_pkg::DATA_ONE))
    else $error("decrement left a wrong null flag");

endmodule : frx_exec

// ===== test/frx_far_model.sv
// Far side of the execute stage: file register array and program counter.
// Assumes combinational reads and one write per strobe; the bench may preset cells.
`timescale 1ns/1ns
module frx_far_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic [4:0] file_addr,
  output logic [7:0] file_rdata,
  input wire logic file_we,
  input wire logic [4:0] file_waddr,
  input wire logic [7:0] file_wdata,
  input wire logic pc_load,
  input wire logic [10:0] pc_target
);
  logic [7:0] regs [32];
  logic [10:0] pc;
  assign file_rdata = regs[file_addr];
  // The fetch side follows a load, otherwise it steps on.
  always @(posedge clk) begin
    if (file_we) regs[file_waddr] <= file_wdata;
    if (reset) pc <= 11'h000;
    else if (pc_load) pc <= pc_target;
    else pc <= pc + 11'h001;
  end
endmodule : frx_far_model

// ===== test/frx_exec_test.sv
// Self-checking bench for the file register execute stage.
// Assumes frx_pkg, the design and the far side model are compiled first.
`timescale 1ns/1ns
module frx_exec_test;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic instr_valid = 1'b0;
  logic [11:0] instr = 12'h000;
  logic [7:0] status_in = 8'h00;
  logic [4:0] file_addr, file_waddr;
  logic [7:0] file_rdata, file_wdata, accum_reg;
  logic file_we, result_null_flag, pc_load, discard_fetched;
  logic [10:0] pc_target;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  frx_exec dut (.clk, .reset, .instr_valid, .instr, .status_in, .file_rdata, .file_addr, .file_we,
    .file_waddr, .file_wdata, .accum_reg, .result_null_flag, .pc_load, .pc_target, .discard_fetched);
  frx_far_model far (.clk, .reset, .file_addr, .file_rdata, .file_we, .file_waddr, .file_wdata,
    .pc_load, .pc_target);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done
  // Presets cell a, offers one instruction and returns just after the answer edge.
  // A call that writes a file register is followed by one on a different cell, so a preset never meets a pending write.
  task automatic run(input logic [11:0] w, input logic [4:0] a, input logic [7:0] v,
                     input logic [11:0] nxt = 12'h000, input logic nv = 1'b0);
    @(posedge clk);
    far.regs[a] <= v;
    instr <= w | {7'h00, a};
    instr_valid <= 1'b1;
    @(posedge clk);
    instr <= nxt;
    instr_valid <= nv;
    #1;
  endtask : run
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_clear;
    run(frx_pkg::CODE_CLEAR, 5'h1F, 8'h5A);
    chk(file_we, 1'b1);
    chk(file_waddr, 5'h1F);
    chk(file_wdata, 8'h00);
    chk(result_null_flag, 1'b1);
    $display("test clear done");
  endtask : t_clear
  task automatic t_ops;
    logic [11:0] ops [6] = '{frx_pkg::CODE_INVERT, frx_pkg::CODE_INVERT, frx_pkg::CODE_DEC,
      frx_pkg::CODE_DEC, frx_pkg::CODE_INC, frx_pkg::CODE_INC};
    logic [7:0] vals [6] = '{8'hFF, 8'h3C, 8'h01, 8'h00, 8'hFF, 8'h7F};
    logic [7:0] exps [6] = '{8'h00, 8'hC3, 8'h00, 8'hFF, 8'h00, 8'h80};
    for (int i = 0; i < 6; i++) begin
      run(ops[i] | {6'h00, i[0], 5'h00}, 5'(i + 1), vals[i]);
      chk(file_we, i[0]);
      if (i[0]) chk(file_wdata, exps[i]);
      else chk(accum_reg, exps[i]);
      chk(result_null_flag, exps[i] == 8'h00);
      chk(discard_fetched, 1'b0);
    end
    $display("test file ops done");
  endtask : t_ops
  task automatic t_skip;
    run(frx_pkg::CODE_OR_LIT | 12'h001, 5'h00, 8'h00);
    chk(result_null_flag, 1'b0);
    run(frx_pkg::CODE_DEC_SKIP, 5'h04, 8'h01);
    chk(accum_reg, 8'h00);
    chk(result_null_flag, 1'b0);
    chk(discard_fetched, 1'b1);
    run(frx_pkg::CODE_INC_SKIP | 12'h020, 5'h05, 8'hFF);
    chk(file_wdata, 8'h00);
    chk(result_null_flag, 1'b0);
    chk(discard_fetched, 1'b1);
    run(frx_pkg::CODE_CLEAR, 5'h06, 8'h11);
    run(frx_pkg::CODE_DEC_SKIP | 12'h020, 5'h07, 8'h05);
    chk(file_wdata, 8'h04);
    chk(result_null_flag, 1'b1);
    chk(discard_fetched, 1'b0);
    run(frx_pkg::CODE_INC_SKIP, 5'h08, 8'h10);
    chk(accum_reg, 8'h11);
    chk(result_null_flag, 1'b1);
    chk(discard_fetched, 1'b0);
    $display("test skips done");
  endtask : t_skip
  // A jump is followed by an OR that lands in the flush cycle and must be dropped.
  task automatic jump(input logic [7:0] st, input logic [11:0] k, input logic [10:0] exp);
    logic [7:0] acc;
    @(posedge clk);
    status_in <= st;
    run(frx_pkg::CODE_JUMP | k, 5'h00, 8'h00, frx_pkg::CODE_OR_LIT | 12'h0FF, 1'b1);
    acc = accum_reg;
    chk(pc_load, 1'b1);
    chk(pc_target, exp);
    chk(discard_fetched, 1'b1);
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    chk(accum_reg, acc);
    chk(discard_fetched, 1'b0);
    chk(pc_load, 1'b0);
    chk(far.pc, exp);
  endtask : jump
  task automatic t_jump;
    jump(8'h40, 12'h1A5, 11'h5A5);
    jump(8'h9F, 12'h1FF, 11'h1FF);
    $display("test jump done");
  endtask : t_jump
  task automatic t_or;
    run(frx_pkg::CODE_INVERT, 5'h09, 8'hFF);
    run(frx_pkg::CODE_OR_LIT, 5'h00, 8'h00);
    chk(accum_reg, 8'h00);
    chk(result_null_flag, 1'b1);
    run(frx_pkg::CODE_OR_LIT | 12'h081, 5'h00, 8'h00);
    run(frx_pkg::CODE_OR_LIT | 12'h024, 5'h00, 8'h00);
    chk(accum_reg, 8'hA5);
    chk(result_null_flag, 1'b0);
    $display("test or literal done");
  endtask : t_or
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc++;
    if (cyc == 500) begin
      n_errors++;
      test_done;
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_clear;
    t_ops;
    t_skip;
    t_jump;
    t_or;
    test_done;
  end
endmodule : frx_exec_test
